// file: rtl/mem_capture_pkg.sv
// Purpose: Shared constants and types for the memory input capture block.
// Assumes: All pins are sampled by sys_clk at 50 MHz through 3 flip-flops.
// Notes:   Input vector bit positions are fixed here and used everywhere.
package mem_capture_pkg;

  // ==========================================================
  // Widths
  localparam int DATA_W = 18;
  localparam int ADDR_W = 23;
  localparam int BANK_W = 3;
  localparam int IN_W = 52;
  localparam int BEAT_W = BANK_W + ADDR_W + 1 + DATA_W;

  // ==========================================================
  // Positions inside the sampled pin vector
  localparam int P_DATA = 0;
  localparam int P_MASK = 18;
  localparam int P_ADDR = 19;
  localparam int P_BANK = 42;
  localparam int P_CS = 45;
  localparam int P_WE = 46;
  localparam int P_REF = 47;
  localparam int P_CKT = 48;
  localparam int P_CKC = 49;
  localparam int P_DKT = 50;
  localparam int P_DKC = 51;

  // ==========================================================
  // Write burst: beats taken per write command
  localparam logic [1:0] BURST_BEATS = 2'h2;
  localparam logic [1:0] LAST_BEAT = 2'h1;

  // ==========================================================
  // Commands and write states, one-hot
  typedef enum logic [3:0] {
    CMD_READ = 4'h1,
    CMD_WRITE = 4'h2,
    CMD_REFRESH = 4'h4,
    CMD_MODE = 4'h8
  } cmd_kind_e;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_BURST = 2'h2
  } wr_state_e;

  // Both control pins low loads the mode register
  function automatic cmd_kind_e decode_cmd(input logic we_n,
                                           input logic ref_n);
    case ({we_n, ref_n})
      2'b00: decode_cmd = CMD_MODE;
      2'b01: decode_cmd = CMD_WRITE;
      2'b10: decode_cmd = CMD_REFRESH;
      default: decode_cmd = CMD_READ;
    endcase
  endfunction : decode_cmd

endpackage : mem_capture_pkg

// file: rtl/beat_buffer.sv
// Purpose: Two-entry buffer for write beats, head always registered.
// Assumes: Single clock domain, sys_clk.
// Notes:   in_ready drops only when both entries hold a beat.
`timescale 1ns/1ps
module beat_buffer #(
  parameter int WIDTH = 45
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  typedef struct packed {
    logic h_v;
    logic [WIDTH-1:0] h_d;
    logic t_v;
    logic [WIDTH-1:0] t_d;
  } buf_s;

  buf_s r;
  buf_s n;

  // ==========================================================
  // Next state
  always_comb begin
    n = r;
    if (r.h_v && out_ready) begin
      n.h_v = r.t_v;
      n.h_d = r.t_d;
      n.t_v = 1'b0;
    end
    if (in_valid && !r.t_v) begin
      if (!n.h_v) begin
        n.h_v = 1'b1;
        n.h_d = in_data;
      end else begin
        n.t_v = 1'b1;
        n.t_d = in_data;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign in_ready = ~r.t_v;
  assign out_valid = r.h_v;
  assign out_data = r.h_d;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  hold_stall_a: assert property (out_valid && !out_ready |=>
      out_valid && $stable(out_data))
    else $error("buffer head changed while stalled");

  full_cov: cover property (r.h_v && r.t_v);

endmodule : beat_buffer

// file: rtl/memory_input_capture.sv
// Purpose: Capture command, address, write data and mask from the pins.
// Assumes: Pin clocks are slow enough for sys_clk to sample every phase.
// Notes:   Pins pass three flops; a change counts when stages 2 and 3 agree.
`timescale 1ns/1ps

module memory_input_capture
  import mem_capture_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cmd_clk_true,
  input wire logic cmd_clk_comp,
  input wire logic [mem_capture_pkg::ADDR_W-1:0] addr,
  input wire logic [mem_capture_pkg::BANK_W-1:0] bank,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic ref_n,
  input wire logic wdata_clk_true,
  input wire logic wdata_clk_comp,
  input wire logic [mem_capture_pkg::DATA_W-1:0] wdata,
  input wire logic write_mask,
  output logic cmd_valid,
  output mem_capture_pkg::cmd_kind_e cmd_kind,
  output logic [mem_capture_pkg::ADDR_W-1:0] cmd_addr,
  output logic [mem_capture_pkg::BANK_W-1:0] cmd_bank,
  output logic [mem_capture_pkg::ADDR_W-1:0] mode_cfg,
  output logic wr_valid,
  output logic [mem_capture_pkg::BEAT_W-1:0] wr_beat,
  input wire logic wr_ready,
  output logic wr_overrun
);
  import mem_capture_pkg::*;

  typedef struct packed {
    logic [IN_W-1:0] s1;
    logic [IN_W-1:0] s2;
    logic [IN_W-1:0] s3;
    logic [IN_W-1:0] st;
    logic ck_lvl;
    logic dk_lvl;
    logic cmd_valid;
    cmd_kind_e cmd_kind;
    logic [ADDR_W-1:0] cmd_addr;
    logic [BANK_W-1:0] cmd_bank;
    logic [ADDR_W-1:0] mode_cfg;
    wr_state_e wr_state;
    logic [1:0] wr_left;
    logic [ADDR_W-1:0] wr_addr;
    logic [BANK_W-1:0] wr_bank;
    logic pend_v;
    logic [BEAT_W-1:0] pend;
    logic overrun;
  } state_s;

  localparam state_s STATE_RST = '{
    cmd_kind: CMD_READ,
    wr_state: WR_IDLE,
    default: '0
  };

  state_s r;
  state_s n;
  logic [IN_W-1:0] pins;
  logic [IN_W-1:0] agree;
  logic ck_now;
  logic ck_rise;
  logic dk_now;
  logic dk_edge;
  logic cmd_go;
  cmd_kind_e cmd_dec;
  logic beat_in;
  logic take;
  logic buf_ready;

  // ==========================================================
  // Pin sampling and edge finding
  assign pins = {wdata_clk_comp, wdata_clk_true, cmd_clk_comp, cmd_clk_true,
                 ref_n, we_n, cs_n, bank, addr, write_mask, wdata};
  assign agree = ~(r.s2 ^ r.s3);

  // A pair with both phases equal is in transit; keep the old level
  assign ck_now = (r.st[P_CKT] != r.st[P_CKC]) ? r.st[P_CKT] : r.ck_lvl;
  assign ck_rise = ck_now & ~r.ck_lvl;
  assign dk_now = (r.st[P_DKT] != r.st[P_DKC]) ? r.st[P_DKT] : r.dk_lvl;
  assign dk_edge = dk_now ^ r.dk_lvl;

  assign cmd_go = ck_rise & ~r.st[P_CS];
  assign cmd_dec = decode_cmd(r.st[P_WE], r.st[P_REF]);
  assign beat_in = dk_edge && (r.wr_state == WR_BURST);
  assign take = r.pend_v & buf_ready;

  // ==========================================================
  // Next state
  always_comb begin
    n = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.st = (agree & r.s3) | (~agree & r.st);
    n.ck_lvl = ck_now;
    n.dk_lvl = dk_now;
    n.cmd_valid = 1'b0;
    if (take) begin
      n.pend_v = 1'b0;
    end

    // Decode only with select low; a burst runs on regardless
    if (cmd_go) begin
      n.cmd_valid = 1'b1;
      n.cmd_kind = cmd_dec;
      n.cmd_addr = r.st[P_ADDR +: ADDR_W];
      n.cmd_bank = r.st[P_BANK +: BANK_W];
      if (cmd_dec == CMD_MODE) begin
        n.mode_cfg = r.st[P_ADDR +: ADDR_W];
      end
    end

    case (r.wr_state)
      WR_IDLE: begin
        n.wr_left = 2'h0;
      end
      WR_BURST: begin
        if (dk_edge) begin
          n.wr_left = r.wr_left - 2'h1;
          if (r.wr_left == LAST_BEAT) begin
            n.wr_state = WR_IDLE;
          end
          // Masked beats never reach the array
          if (!r.st[P_MASK]) begin
            if (!r.pend_v || take) begin
              n.pend_v = 1'b1;
              n.pend = {r.wr_bank, r.wr_addr, r.wr_left == LAST_BEAT,
                        r.st[P_DATA +: DATA_W]};
            end else begin
              // Sink stalled past three beats (pend plus both entries): beat lost, flag sticks
              n.overrun = 1'b1;
            end
          end
        end
      end
      default: begin
        n.wr_state = WR_IDLE;
      end
    endcase

    // A new write restarts the burst, even mid-burst
    if (cmd_go && cmd_dec == CMD_WRITE) begin
      n.wr_state = WR_BURST;
      n.wr_left = BURST_BEATS;
      n.wr_addr = r.st[P_ADDR +: ADDR_W];
      n.wr_bank = r.st[P_BANK +: BANK_W];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      r <= STATE_RST;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // Beat buffer toward the array
  beat_buffer #(
    .WIDTH(BEAT_W)
  ) u_buf (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(r.pend_v),
    .in_data(r.pend),
    .in_ready(buf_ready),
    .out_valid(wr_valid),
    .out_data(wr_beat),
    .out_ready(wr_ready)
  );

  assign cmd_valid = r.cmd_valid;
  assign cmd_kind = r.cmd_kind;
  assign cmd_addr = r.cmd_addr;
  assign cmd_bank = r.cmd_bank;
  assign mode_cfg = r.mode_cfg;
  assign wr_overrun = r.overrun;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  addr_capture_a: assert property (cmd_go |=>
      cmd_valid && cmd_addr == $past(r.st[P_ADDR +: ADDR_W]))
    else $error("command address not captured");

  mode_load_a: assert property (
      cmd_go && cmd_dec == CMD_MODE |=> mode_cfg == cmd_addr)
    else $error("mode configuration not loaded from address");

  rise_only_a: assert property (
      cmd_valid |-> $past(ck_rise) && !$past(ck_rise, 2))
    else $error("command taken off the rising edge");

  bank_pick_a: assert property (cmd_go |=>
      cmd_bank == $past(r.st[P_BANK +: BANK_W]))
    else $error("bank not captured");

  select_gate_a: assert property (
      ck_rise && r.st[P_CS] |=> !cmd_valid && $stable(mode_cfg))
    else $error("command decoded with select high");

  cmd_decode_a: assert property (cmd_go |=>
      cmd_kind == decode_cmd($past(r.st[P_WE]), $past(r.st[P_REF])))
    else $error("command kind wrong");

  beat_take_a: assert property (
      beat_in && !r.st[P_MASK] && !r.pend_v |=>
      r.pend_v && r.pend[DATA_W-1:0] == $past(r.st[P_DATA +: DATA_W]))
    else $error("unmasked beat not captured");

  mask_drop_a: assert property (
      beat_in && r.st[P_MASK] |=>
      r.pend_v == $past(r.pend_v && !take) && !$rose(r.overrun))
    else $error("masked beat was forwarded");

  burst_len_a: assert property (
      cmd_go && cmd_dec == CMD_WRITE |=> r.wr_state == WR_BURST
      && r.wr_left == BURST_BEATS)
    else $error("write burst not armed");

  write_cov: cover property (beat_in && !r.st[P_MASK]);
  mask_cov: cover property (beat_in && r.st[P_MASK]);
  mode_cov: cover property (cmd_valid && cmd_kind == CMD_MODE);
  stall_cov: cover property (r.pend_v && !buf_ready);

endmodule : memory_input_capture

// file: dv/ctrl_model.sv
// Purpose: Controller model driving command, address and write pins.
// Assumes: Pin clocks free running at 160 ns once reset is released.
// Notes: Data clock lags the command clock by 40 ns.
`timescale 1ns/1ps
module ctrl_model
  import mem_capture_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  output logic cmd_clk_true,
  output logic cmd_clk_comp,
  output logic [mem_capture_pkg::ADDR_W-1:0] addr,
  output logic [mem_capture_pkg::BANK_W-1:0] bank,
  output logic cs_n,
  output logic we_n,
  output logic ref_n,
  output logic wdata_clk_true,
  output logic wdata_clk_comp,
  output logic [mem_capture_pkg::DATA_W-1:0] wdata,
  output logic write_mask
);
  // ==========================================
  // Clocks
  assign cmd_clk_comp = ~cmd_clk_true;
  assign wdata_clk_comp = ~wdata_clk_true;
  initial begin
    {cmd_clk_true, wdata_clk_true, write_mask} = 3'h0;
    {cs_n, we_n, ref_n} = 3'h7;
    addr = '0;
    bank = '0;
    wdata = '0;
    // Start after reset so the sync chain sees stable pins
    @(posedge nrst);
    #113;
    fork
      forever #80 cmd_clk_true = ~cmd_clk_true;
      begin
        #40;
        forever #80 wdata_clk_true = ~wdata_clk_true;
      end
    join
  end
  // ==========================================
  // One command, pins moved mid-phase of each clock
  task automatic issue(input logic [2:0] c, input logic [ADDR_W-1:0] a,
      input logic [BANK_W-1:0] b, input logic [DATA_W-1:0] d0,
      input logic [DATA_W-1:0] d1, input logic [1:0] m);
    @(negedge cmd_clk_true);
    @(posedge sys_clk);
    {cs_n, we_n, ref_n} <= c;
    addr <= a;
    bank <= b;
    wdata <= ~wdata;
    write_mask <= 1'b0;
    @(posedge cmd_clk_true);
    @(posedge sys_clk);
    wdata <= d0;
    write_mask <= m[0];
    @(negedge cmd_clk_true);
    @(posedge sys_clk);
    // Deselect so the idle rise is not a repeat
    cs_n <= 1'b1;
    addr <= ~a;
    wdata <= d1;
    write_mask <= m[1];
  endtask : issue
endmodule : ctrl_model

// file: dv/memory_input_capture_tb.sv
// Purpose: Self-checking bench for the memory input capture block.
// Assumes: ctrl_model drives every pin.
// Notes: Expectations queued when each command is sent.
`timescale 1ns/1ps
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin \
  fail_count++; $display("mismatch t=%0t got %h", $time, act); end end
module memory_input_capture_tb;
  import mem_capture_pkg::*;
  logic sys_clk, nrst, wr_ready, rand_rdy, fix_rdy, cmd_valid, wr_valid;
  logic cmd_clk_true, cmd_clk_comp, cs_n, we_n, ref_n, wr_overrun;
  logic wdata_clk_true, wdata_clk_comp, write_mask;
  logic [ADDR_W-1:0] addr, mode_cfg, cmd_addr, exp_mode;
  logic [BANK_W-1:0] bank, cmd_bank;
  logic [DATA_W-1:0] wdata;
  cmd_kind_e cmd_kind;
  logic [BEAT_W-1:0] wr_beat;
  logic [BEAT_W-1:0] bq[$];
  logic [52:0] cq[$];
  logic [52:0] ce;
  logic [15:0] seed, seed2;
  int fail_count, comparisons;
  ctrl_model u_ctrl (.sys_clk, .nrst, .cmd_clk_true, .cmd_clk_comp,
    .addr, .bank, .cs_n, .we_n, .ref_n, .wdata_clk_true,
    .wdata_clk_comp, .wdata, .write_mask);
  memory_input_capture u_dut (.sys_clk, .nrst, .cmd_clk_true,
    .cmd_clk_comp, .addr, .bank, .cs_n, .we_n, .ref_n, .wdata_clk_true,
    .wdata_clk_comp, .wdata, .write_mask, .cmd_valid, .cmd_kind,
    .cmd_addr, .cmd_bank, .mode_cfg, .wr_valid, .wr_beat, .wr_ready,
    .wr_overrun);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic cmd_kind_e kind_of(input logic [1:0] w);
    kind_of = w == 2'h0 ? CMD_MODE : w == 2'h1 ? CMD_WRITE :
      w == 2'h2 ? CMD_REFRESH : CMD_READ;
  endfunction : kind_of
  // ==========================================
  // Stimulus and expectation
  task automatic send(input logic [2:0] c, input logic [1:0] m);
    logic [63:0] r;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      r = {r[47:0], seed};
    end
    if (!c[2]) begin
      if (c[1:0] == 2'h0) exp_mode = r[22:0];
      cq.push_back({exp_mode, kind_of(c[1:0]), r[25:0]});
      if (c[1:0] == 2'h1 && !m[0]) bq.push_back({r[25:0], 1'b0, r[43:26]});
      if (c[1:0] == 2'h1 && !m[1]) bq.push_back({r[25:0], 1'b1, r[61:44]});
    end
    u_ctrl.issue(c, r[22:0], r[25:23], r[43:26], r[61:44], m);
  endtask : send
  task automatic drain;
    for (int i = 0; i < 300 && cq.size() + bq.size() > 0; i++)
      @(posedge sys_clk);
    `CHK(cq.size() + bq.size(), 0)
  endtask : drain
  task automatic final_report;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // ==========================================
  // Monitors; ready stalls one cycle in four
  always @(posedge sys_clk) begin
    seed2 <= nrst ? lfsr(seed2) : 16'hae67;
    wr_ready <= rand_rdy ? seed2[0] | seed2[1] : fix_rdy;
    if (cmd_valid === 1'b1) begin
      if (cq.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        ce = cq.pop_front();
        `CHK(cmd_kind, ce[29:26])
        `CHK(cmd_bank, ce[25:23])
        `CHK(cmd_addr, ce[22:0])
        `CHK(mode_cfg, ce[52:30])
      end
    end
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (bq.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK(wr_beat, bq.pop_front())
    end
  end
  initial begin
    #100_000;
    fail_count++;
    final_report;
  end
  initial begin
    seed = 16'hae67;
    exp_mode = '0;
    fail_count = 0;
    comparisons = 0;
    {fix_rdy, rand_rdy, nrst} = 3'h6;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int k = 0; k < 4; k++) send({1'b0, 2'(k)}, 2'h0);
    send(3'h5, 2'h0);
    for (int k = 1; k < 4; k++) send(3'h1, 2'(k));
    drain;
    $display("test corner done");
    repeat (24) begin
      seed = lfsr(seed);
      send({seed[0] & seed[1], seed[3:2]},
        seed[3:2] == 2'h1 ? seed[5:4] : 2'h0);
    end
    drain;
    $display("test random done");
    // Receiver stalls: three beats held, the fourth is lost
    rand_rdy <= 1'b0;
    fix_rdy <= 1'b0;
    send(3'h1, 2'h0);
    send(3'h1, 2'h0);
    void'(bq.pop_back());
    for (int i = 0; i < 40 && wr_overrun !== 1'b1; i++)
      @(posedge sys_clk);
    `CHK(wr_overrun, 1'b1)
    fix_rdy <= 1'b1;
    drain;
    $display("test overrun done");
    final_report;
  end
endmodule : memory_input_capture_tb
